// ==== rtl/adcc_top.sv ====
// Converter control block with APB register access and SAR sequencing.
`default_nettype none

module adcc_top #(
    parameter int RESULT_W = adcc_pkg::ADCC_RESULT_W
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 sleep_enter,
    input  wire logic                 comparator_in,
    output logic      [1:0]           analog_input_sel,
    output logic                      dac_enable,
    output logic      [RESULT_W-1:0]  dac_trial,
    output logic                      sample_hold,
    output logic      [1:0]           digital_drive_block,
    output logic                      converter_power_on
);
    import adcc_pkg::*;

    // ****************************************************************
    // Control state.
    // ****************************************************************
    logic [1:0]          analog_pin_select;
    logic [1:0]          channel_select;
    logic                go_done;
    logic [1:0]          div_cnt;
    logic [3:0]          period_cnt;
    logic [RESULT_W-1:0] sar;
    logic [RESULT_W-1:0] conversion_result;
    logic                resolved_any;
    adcc_state_t         state;
    logic                cmp_meta;
    logic                cmp_sync;
    logic                tick;
    logic                wr_ctrl;
    logic                apb_access;
    logic                addr_ok;

    assign apb_access = psel && penable;
    assign wr_ctrl    = apb_access && pwrite && (paddr == ADCC_CTRL_OFFSET);
    assign tick       = (div_cnt == 2'(ADCC_CLK_DIV - 1));
    assign addr_ok    = (paddr == ADCC_CTRL_OFFSET) ||
                        (paddr == ADCC_RESULT_OFFSET) ||
                        (paddr == ADCC_STATUS_OFFSET);

    // Comparator comes from the analog side, so it is synchronised first.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= comparator_in;
            cmp_sync <= cmp_meta;
        end
    end

    // Bit period divider; held at zero while idle, so that periods are always four clocks.
    always_ff @(posedge mclk) begin
        if (!rst_n || state == ADCC_IDLE) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= div_cnt + 2'h1;
        end
    end

    // Analog select survives sleep, only reset restores it.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            analog_pin_select <= ADCC_ANS_RESET;
        end else if (wr_ctrl && !sleep_enter) begin
            analog_pin_select <= pwdata[ADCC_ANS_LSB +: 2];
        end
    end

    // Channel select is lost on sleep entry.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            channel_select <= ADCC_CHS_RESET;
        end else if (sleep_enter) begin
            channel_select <= ADCC_CHS_RESET;
        end else if (wr_ctrl) begin
            channel_select <= pwdata[ADCC_CHS_LSB +: 2];
        end
    end

    // Power bit; sleep wins over a simultaneous write.
    always_ff @(posedge mclk) begin
        if (!rst_n || sleep_enter) begin
            converter_power_on <= 1'b0;
        end else if (wr_ctrl) begin
            converter_power_on <= pwdata[ADCC_POWER_BIT];
        end
    end

    // Go/done: software start and abort, hardware clear at completion.
    // A start is honoured only if the converter is already powered, so
    // a single write setting both bits does not start a conversion.
    always_ff @(posedge mclk) begin
        if (!rst_n || sleep_enter) begin
            go_done <= 1'b0;
        end else if (wr_ctrl) begin
            go_done <= pwdata[ADCC_GO_BIT] && converter_power_on;
        end else if (state == ADCC_CONVERT && tick &&
                     period_cnt == 4'(ADCC_BIT_PERIODS - 1)) begin
            go_done <= 1'b0;
        end
    end

    // Sequencer: two sample periods, eight bit decisions, three settle.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state      <= ADCC_IDLE;
            period_cnt <= 4'h0;
        end else if (!go_done || sleep_enter) begin
            state      <= ADCC_IDLE;
            period_cnt <= 4'h0;
        end else begin
            unique case (state)
                ADCC_IDLE: begin
                    state      <= ADCC_SAMPLE;
                    period_cnt <= 4'h0;
                end
                ADCC_SAMPLE: begin
                    if (tick) begin
                        period_cnt <= period_cnt + 4'h1;
                        if (period_cnt == 4'h1) begin
                            state <= ADCC_CONVERT;
                        end
                    end
                end
                ADCC_CONVERT: begin
                    if (tick) begin
                        period_cnt <= period_cnt + 4'h1;
                    end
                end
            endcase
        end
    end

    // Successive approximation register; bit index from the period count.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sar          <= '0;
            resolved_any <= 1'b0;
        end else if (state == ADCC_SAMPLE) begin
            sar          <= {1'b1, {(RESULT_W-1){1'b0}}};
            resolved_any <= 1'b0;
        end else if (state == ADCC_CONVERT && tick &&
                     period_cnt < 4'(2 + RESULT_W)) begin
            for (int i = 0; i < RESULT_W; i++) begin
                if (i == int'(period_cnt) - 2) begin
                    sar[RESULT_W-1-i] <= cmp_sync;
                    if (RESULT_W-2-i >= 0) begin
                        sar[RESULT_W-2-i] <= 1'b1;
                    end
                end
            end
            resolved_any <= 1'b1;
        end
    end

    // Result register: final value at completion, partial on any abort
    // only once a bit has been decided; reset leaves it untouched.
    always_ff @(posedge mclk) begin
        if (state == ADCC_CONVERT && tick &&
            period_cnt == 4'(ADCC_BIT_PERIODS - 1) && !sleep_enter &&
            !wr_ctrl) begin
            conversion_result <= sar;
        end else if (state != ADCC_IDLE && resolved_any &&
                     (sleep_enter || (wr_ctrl && !pwdata[ADCC_GO_BIT]))) begin
            conversion_result <= sar;
        end
    end

    // Pin and analog front-end outputs, all registered.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            analog_input_sel    <= ADCC_CHS_RESET;
            digital_drive_block <= ADCC_ANS_RESET;
            dac_enable          <= 1'b0;
            dac_trial           <= '0;
            sample_hold         <= 1'b0;
        end else begin
            analog_input_sel    <= channel_select;
            digital_drive_block <= analog_pin_select;
            dac_enable          <= converter_power_on;
            dac_trial           <= sar;
            sample_hold         <= (state == ADCC_CONVERT);
        end
    end

    // APB slave: zero wait states, error on unmapped access or on a result or status write.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable &&
                       (!addr_ok || (pwrite && paddr != ADCC_CTRL_OFFSET));
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    ADCC_CTRL_OFFSET: prdata <= {24'h00_0000,
                        analog_pin_select, 2'b00, channel_select,
                        go_done, converter_power_on};
                    ADCC_RESULT_OFFSET:
                        prdata <= {{(32-RESULT_W){1'b0}}, conversion_result};
                    ADCC_STATUS_OFFSET: prdata <= {28'h000_0000,
                        resolved_any, 1'b0, state};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ==== shared/adcc_pkg.sv ====
// Package of register map, field layout and timing constants for the converter control.
`default_nettype none

package adcc_pkg;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam logic [11:0] ADCC_CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] ADCC_RESULT_OFFSET = 12'h004;
    localparam logic [11:0] ADCC_STATUS_OFFSET = 12'h008;

    // ****************************************************************
    // Control register field positions.
    // ****************************************************************
    localparam int ADCC_POWER_BIT = 0;
    localparam int ADCC_GO_BIT    = 1;
    localparam int ADCC_CHS_LSB   = 2;
    localparam int ADCC_ANS_LSB   = 6;

    // ****************************************************************
    // Reset values and timing.
    // ****************************************************************
    localparam logic [1:0] ADCC_ANS_RESET  = 2'h3;
    localparam logic [1:0] ADCC_CHS_RESET  = 2'h3;
    localparam int         ADCC_CLK_DIV    = 4;
    localparam int         ADCC_BIT_PERIODS = 13;
    localparam int         ADCC_RESULT_W   = 8;

    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_SAMPLE,
        ADCC_CONVERT
    } adcc_state_t;

endpackage

`default_nettype wire

// ==== sim/adcc_checker.sv ====
// Port-level assertions for the converter control block.
`default_nettype none
module adcc_checker (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleep_enter,
    input wire logic [1:0]  analog_input_sel,
    input wire logic [1:0]  digital_drive_block,
    input wire logic        sample_hold,
    input wire logic        converter_power_on
);
    import adcc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic wr_ctrl;
    // Sleep wins over a same-cycle write, so such writes are left out.
    assign wr_ctrl = psel && penable && pready && pwrite && !sleep_enter
                     && paddr == ADCC_CTRL_OFFSET;
    // A setup cycle is answered once, in the following cycle.
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_ready_pulse: assert property (s_setup |=> s_answer)
        else $error("pready is not a one-cycle answer.");
    // The result register refuses writes with an error answer.
    a_result_ro: assert property (psel && !penable && pwrite &&
        paddr == ADCC_RESULT_OFFSET |=> pready && pslverr)
        else $error("Write to result not refused.");
    a_reset_value: assert property ($rose(rst_n) |->
        digital_drive_block == ADCC_ANS_RESET && !converter_power_on)
        else $error("Wrong values after reset.");
    // Pin outputs sit one register behind the control fields.
    a_ans_drive: assert property (wr_ctrl |-> ##2
        digital_drive_block == $past(pwdata[ADCC_ANS_LSB+:2], 2))
        else $error("Drive block does not follow pin select.");
    a_chs_route: assert property (wr_ctrl |-> ##2
        analog_input_sel == $past(pwdata[ADCC_CHS_LSB+:2], 2))
        else $error("Channel not routed.");
    a_power_write: assert property (wr_ctrl |=>
        converter_power_on == $past(pwdata[ADCC_POWER_BIT]))
        else $error("Power bit not written.");
    a_sleep_off: assert property (sleep_enter |=>
        !converter_power_on ##1 !sample_hold)
        else $error("Sleep did not stop the converter.");
    a_sleep_chs: assert property (sleep_enter |-> ##2
        analog_input_sel == ADCC_CHS_RESET)
        else $error("Sleep did not force the channel.");
    a_sleep_ans: assert property (sleep_enter |=>
        $stable(digital_drive_block))
        else $error("Sleep changed the pin select.");
endmodule
bind adcc_top adcc_checker adcc_checker_i (.mclk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .sleep_enter,
    .analog_input_sel, .digital_drive_block, .sample_hold,
    .converter_power_on);
`default_nettype wire

// ==== sim/adcc_top_tb.sv ====
// Self-checking bench for the converter control block.
`default_nettype none
module adcc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adcc_pkg::*;
    logic        mclk = 1'b0, rst_n, psel, penable, pwrite, sleep_enter, cmp;
    logic        pready, pslverr, e, pw;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  ais, ddb;
    int          fails = 0, n_compared = 0, cyc = 0, el;
    time         t0;
    adcc_top adcc_top_i (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sleep_enter,
        .comparator_in(cmp), .analog_input_sel(ais), .dac_enable(),
        .dac_trial(), .sample_hold(), .digital_drive_block(ddb),
        .converter_power_on(pw));
    // Clock at 250 MHz.
    always #2 mclk = ~mclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the leading edge keeps drives one per time step.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reset;
        rst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Cuts a hang short; the tests need well under a thousand cycles.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, sleep_enter, cmp} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        reset();
        apb(1'b0, ADCC_CTRL_OFFSET, 32'h0000_0000);
        chk(r, 32'h0000_00cc);
        apb(1'b1, ADCC_CTRL_OFFSET, 32'h0000_00ce);
        apb(1'b0, ADCC_CTRL_OFFSET, 32'h0000_0000);
        chk(r, 32'h0000_00cc);
        $display("reset and refused start done.");
        // Comparator high keeps every trial bit, low drops every one.
        for (int v = 1; v >= 0; v--) begin
            cmp <= v[0];
            apb(1'b1, ADCC_CTRL_OFFSET, 32'h0000_00c1);
            apb(1'b1, ADCC_CTRL_OFFSET, 32'h0000_00c3);
            t0 = $time;
            do apb(1'b0, ADCC_CTRL_OFFSET, 32'h0000_0000); while (r[1]);
            el = int'(($time - t0) / 4);
            chk({31'h0, el >= 50 && el <= 58}, 32'h1);
            chk(r, 32'h0000_00c1);
            apb(1'b0, ADCC_RESULT_OFFSET, 32'h0000_0000);
            chk(r, v[0] ? 32'h0000_00ff : 32'h0000_0000);
        end
        $display("conversions done.");
        apb(1'b1, ADCC_CTRL_OFFSET, 32'h0000_00c3);
        repeat (30) @(posedge mclk);
        apb(1'b1, ADCC_CTRL_OFFSET, 32'h0000_00c1);
        apb(1'b0, ADCC_CTRL_OFFSET, 32'h0000_0000);
        chk(r, 32'h0000_00c1);
        apb(1'b1, ADCC_CTRL_OFFSET, 32'h0000_00c0);
        apb(1'b0, ADCC_CTRL_OFFSET, 32'h0000_0000);
        chk(r, 32'h0000_00c0);
        apb(1'b1, ADCC_CTRL_OFFSET, 32'h0000_0045);
        apb(1'b1, ADCC_CTRL_OFFSET, 32'h0000_0047);
        repeat (20) @(posedge mclk);
        sleep_enter <= 1'b1;
        @(posedge mclk);
        sleep_enter <= 1'b0;
        apb(1'b0, ADCC_CTRL_OFFSET, 32'h0000_0000);
        chk(r, 32'h0000_004c);
        chk({30'h0, ddb}, 32'h1);
        chk({30'h0, ais}, 32'h3);
        chk({31'h0, pw}, 32'h0);
        $display("abort and sleep done.");
        apb(1'b1, ADCC_RESULT_OFFSET, 32'h0000_0055);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk({31'h0, e}, 32'h1);
        reset();
        apb(1'b0, ADCC_CTRL_OFFSET, 32'h0000_0000);
        chk(r, 32'h0000_00cc);
        $display("errors and wake done.");
        tally_and_finish();
    end
endmodule
`default_nettype wire
